// ==== preamp_consts.vh ====
// constants for the rgb overlay clamp control block
`ifndef PREAMP_CONSTS_VH
`define PREAMP_CONSTS_VH
// =====================================================
// serial bus
`define SLAVE_ADDR_WR 8'hdc
// =====================================================
// register indexes
`define REG_CONTRAST 8'h00
`define REG_BRIGHTNESS 8'h01
`define REG_DRIVE_FIRST 8'h02
`define REG_DRIVE_SECOND 8'h03
`define REG_DRIVE_THIRD 8'h04
`define REG_OVERLAY_AMP 8'h05
`define REG_CLAMP_CONFIG 8'h08
// =====================================================
// clamp config bit positions
`define CFG_SYNC_SEL 0
`define CFG_WIDTH_LO 1
`define CFG_WIDTH_HI 2
`define CFG_SEMI_EN 6
`define CFG_BLANK_POL 7
// =====================================================
// reset values
`define RST_CONTRAST 8'hb3
`define RST_BRIGHTNESS 8'h00
`define RST_DRIVE 8'hb3
`define RST_OVERLAY_AMP 8'h00
`define RST_CLAMP_CONFIG 8'h00
// =====================================================
// overlay amplitude: 0.36 v steps, 5.5 v ceiling (in 10 mv units)
`define OVERLAY_STEP_10MV 16'd36
`define OVERLAY_MAX_10MV 16'd550
`define OVERLAY_MAX_CODE 8'h0f
// =====================================================
// clamp gate widths in ns, per two-bit width code
`define CLK_PERIOD_NS 5
`define GATE_W0_NS 330
`define GATE_W1_NS 660
`define GATE_W2_NS 1000
`define GATE_W3_NS 1330
`define GATE_W0_CYC ((`GATE_W0_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GATE_W1_CYC ((`GATE_W1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GATE_W2_CYC ((`GATE_W2_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GATE_W3_CYC ((`GATE_W3_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== serial_write_slave.v ====
// write-only two-wire serial slave, pins sampled on the core clock
`timescale 1ns/100ps
`default_nettype none
`include "preamp_consts.vh"
module serial_write_slave (
  input wire clk_in,
  input wire rst_n_in,
  input wire scl_in,
  input wire sda_in,
  output reg sda_oe_n_out,
  output reg wr_stb_out,
  output reg [7:0] wr_addr_out,
  output reg [7:0] wr_data_out
);
  localparam ST_IDLE = 2'd0;
  localparam ST_ADDR = 2'd1;
  localparam ST_REG = 2'd2;
  localparam ST_DATA = 2'd3;
  // =====================================================
  // pin synchronisers
  reg scl_s1_reg, scl_s2_reg, scl_s3_reg;
  reg sda_s1_reg, sda_s2_reg, sda_s3_reg;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
    end
  end
  wire scl_rise = scl_s2_reg & ~scl_s3_reg;
  wire scl_fall = ~scl_s2_reg & scl_s3_reg;
  wire start_cond = scl_s2_reg & scl_s3_reg & ~sda_s2_reg & sda_s3_reg;
  wire stop_cond = scl_s2_reg & scl_s3_reg & sda_s2_reg & ~sda_s3_reg;
  // =====================================================
  // byte engine
  reg [1:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg ack_pend_reg;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ack_pend_reg <= 1'b0;
      sda_oe_n_out <= 1'b1;
      wr_stb_out <= 1'b0;
      wr_addr_out <= 8'h00;
      wr_data_out <= 8'h00;
    end else begin
      wr_stb_out <= 1'b0;
      if (start_cond) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_n_out <= 1'b1;
        ack_pend_reg <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= ST_IDLE;
        sda_oe_n_out <= 1'b1;
      end else if (state_reg != ST_IDLE) begin
        if (scl_rise && bit_cnt_reg < 4'd8) begin
          shift_reg <= {shift_reg[6:0], sda_s2_reg}; // msb first
          bit_cnt_reg <= bit_cnt_reg + 4'd1;
        end else if (scl_fall && bit_cnt_reg == 4'd8) begin
          bit_cnt_reg <= 4'd9;
          case (state_reg)
            ST_ADDR: begin
              // only a write to our address is acknowledged
              if (shift_reg == `SLAVE_ADDR_WR) begin
                sda_oe_n_out <= 1'b0;
                ack_pend_reg <= 1'b1;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
            ST_REG: begin
              wr_addr_out <= shift_reg;
              sda_oe_n_out <= 1'b0;
              ack_pend_reg <= 1'b1;
            end
            ST_DATA: begin
              wr_data_out <= shift_reg;
              wr_stb_out <= 1'b1;
              sda_oe_n_out <= 1'b0;
              ack_pend_reg <= 1'b1;
            end
            default: state_reg <= ST_IDLE;
          endcase
        end else if (scl_fall && bit_cnt_reg == 4'd9) begin
          sda_oe_n_out <= 1'b1;
          bit_cnt_reg <= 4'h0;
          if (ack_pend_reg) begin
            ack_pend_reg <= 1'b0;
            // sequence addr, reg, data; data bytes auto-step the index
            case (state_reg)
              ST_ADDR: state_reg <= ST_REG;
              ST_REG: state_reg <= ST_DATA;
              ST_DATA: wr_addr_out <= wr_addr_out + 8'h01;
              default: state_reg <= ST_IDLE;
            endcase
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== clamp_gate_gen.v ====
// back-porch clamp gate pulse generator
`timescale 1ns/100ps
`default_nettype none
`include "preamp_consts.vh"
module clamp_gate_gen (
  input wire clk_in,
  input wire rst_n_in,
  input wire sync_sel_in,
  input wire [1:0] width_sel_in,
  input wire blank_act_in,
  input wire hsync_in,
  output reg gate_out
);
  function [8:0] width_cycles;
    input [1:0] sel;
    reg [31:0] cyc;
    begin
      case (sel)
        2'd0: cyc = `GATE_W0_CYC;
        2'd1: cyc = `GATE_W1_CYC;
        2'd2: cyc = `GATE_W2_CYC;
        default: cyc = `GATE_W3_CYC;
      endcase
      // widest code still fits nine bits
      width_cycles = cyc[8:0];
    end
  endfunction
  // =====================================================
  // sync polarity follows the majority level: idle is the long state
  reg blank_d_reg, hsync_d_reg;
  reg [9:0] hi_cnt_reg;
  reg sync_low_act_reg;
  reg [8:0] cnt_reg;
  wire blank_lead = blank_act_in & ~blank_d_reg;
  wire hsync_act = hsync_in ^ sync_low_act_reg;
  wire hsync_act_d = hsync_d_reg ^ sync_low_act_reg;
  wire hsync_second = ~hsync_act & hsync_act_d;
  wire trig = sync_sel_in ? blank_lead : hsync_second;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      blank_d_reg <= 1'b0;
      hsync_d_reg <= 1'b0;
      hi_cnt_reg <= 10'h200;
      sync_low_act_reg <= 1'b0;
      cnt_reg <= 9'h000;
      gate_out <= 1'b0;
    end else begin
      blank_d_reg <= blank_act_in;
      hsync_d_reg <= hsync_in;
      // saturating up/down vote on the level seen
      if (hsync_in && hi_cnt_reg != 10'h3ff)
        hi_cnt_reg <= hi_cnt_reg + 10'h001;
      else if (!hsync_in && hi_cnt_reg != 10'h000)
        hi_cnt_reg <= hi_cnt_reg - 10'h001;
      sync_low_act_reg <= hi_cnt_reg[9];
      if (trig) begin
        // leading blank edge or trailing sync edge
        cnt_reg <= width_cycles(width_sel_in);
        gate_out <= 1'b1;
      end else if (cnt_reg > 9'h001) begin
        cnt_reg <= cnt_reg - 9'h001;
      end else begin
        cnt_reg <= 9'h000;
        gate_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rgb_overlay_clamp_control.v ====
// control core of the three-channel rgb preamplifier
`timescale 1ns/100ps
`default_nettype none
`include "preamp_consts.vh"
module rgb_overlay_clamp_control (
  input wire clk_in,
  input wire rst_n_in,
  input wire scl_in,
  input wire sda_in,
  output reg sda_oe_n_out,
  input wire fast_blank_input_in,
  input wire blanking_input_in,
  input wire hsync_in,
  input wire overlay_in_first_in,
  input wire overlay_in_second_in,
  input wire overlay_in_third_in,
  output reg clamp_gate_pulse_out,
  output reg picture_mute_out,
  output reg infra_black_out,
  output reg [1:0] channel_sel_first_out,
  output reg [1:0] channel_sel_second_out,
  output reg [1:0] channel_sel_third_out,
  output reg [7:0] contrast_gain_out,
  output reg [7:0] brightness_offset_out,
  output reg [7:0] drive_first_out,
  output reg [7:0] drive_second_out,
  output reg [7:0] drive_third_out,
  output reg [15:0] overlay_amp_10mv_out
);
  // channel selector codes
  localparam SEL_VIDEO = 2'd0;
  localparam SEL_BRIGHT = 2'd1;
  localparam SEL_OVERLAY = 2'd2;
  localparam SEL_SEMI = 2'd3;
  // =====================================================
  // serial bus
  wire bus_oe_n;
  wire wr_stb;
  wire [7:0] wr_addr;
  wire [7:0] wr_data;
  serial_write_slave bus_slave (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_n_out(bus_oe_n),
    .wr_stb_out(wr_stb),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data)
  );
  // =====================================================
  // control registers
  reg [7:0] contrast_reg;
  reg [7:0] brightness_reg;
  reg [7:0] drive_first_reg, drive_second_reg, drive_third_reg;
  reg [7:0] overlay_amp_reg;
  reg [7:0] clamp_config_register_reg;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      contrast_reg <= `RST_CONTRAST;
      brightness_reg <= `RST_BRIGHTNESS;
      drive_first_reg <= `RST_DRIVE;
      drive_second_reg <= `RST_DRIVE;
      drive_third_reg <= `RST_DRIVE;
      overlay_amp_reg <= `RST_OVERLAY_AMP;
      clamp_config_register_reg <= `RST_CLAMP_CONFIG; // positive blanking
    end else if (wr_stb) begin
      // held until rewritten, no extra commit step
      case (wr_addr)
        `REG_CONTRAST: contrast_reg <= wr_data;
        `REG_BRIGHTNESS: brightness_reg <= wr_data;
        `REG_DRIVE_FIRST: drive_first_reg <= wr_data;
        `REG_DRIVE_SECOND: drive_second_reg <= wr_data;
        `REG_DRIVE_THIRD: drive_third_reg <= wr_data;
        `REG_OVERLAY_AMP: overlay_amp_reg <= wr_data;
        `REG_CLAMP_CONFIG: clamp_config_register_reg <= wr_data;
        default: contrast_reg <= contrast_reg;
      endcase
    end
  end
  wire clamp_sync_select_bit = clamp_config_register_reg[`CFG_SYNC_SEL];
  wire blank_polarity_bit = clamp_config_register_reg[`CFG_BLANK_POL];
  wire semi_transparent_enable_bit = clamp_config_register_reg[`CFG_SEMI_EN];
  wire [1:0] gate_width = clamp_config_register_reg[`CFG_WIDTH_HI:`CFG_WIDTH_LO];
  // =====================================================
  // pin synchronisers
  reg [1:0] fb_sync_reg, blk_sync_reg, hs_sync_reg;
  reg [1:0] ov1_sync_reg, ov2_sync_reg, ov3_sync_reg;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      fb_sync_reg <= 2'b00;
      blk_sync_reg <= 2'b00;
      hs_sync_reg <= 2'b00;
      ov1_sync_reg <= 2'b00;
      ov2_sync_reg <= 2'b00;
      ov3_sync_reg <= 2'b00;
    end else begin
      fb_sync_reg <= {fb_sync_reg[0], fast_blank_input_in};
      blk_sync_reg <= {blk_sync_reg[0], blanking_input_in};
      hs_sync_reg <= {hs_sync_reg[0], hsync_in};
      ov1_sync_reg <= {ov1_sync_reg[0], overlay_in_first_in};
      ov2_sync_reg <= {ov2_sync_reg[0], overlay_in_second_in};
      ov3_sync_reg <= {ov3_sync_reg[0], overlay_in_third_in};
    end
  end
  wire blank_act = blk_sync_reg[1] ^ blank_polarity_bit;
  wire fast_blank = fb_sync_reg[1];
  // =====================================================
  // clamp gate
  wire gate;
  clamp_gate_gen gate_gen (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .sync_sel_in(clamp_sync_select_bit),
    .width_sel_in(gate_width),
    .blank_act_in(blank_act),
    .hsync_in(hs_sync_reg[1]),
    .gate_out(gate)
  );
  // =====================================================
  // overlay switch
  function [1:0] chan_sel;
    input fb;
    input ov;
    input semi;
    begin
      if (!fb)
        chan_sel = SEL_VIDEO;
      else if (semi)
        chan_sel = SEL_SEMI;
      else if (ov)
        chan_sel = SEL_OVERLAY;
      else
        chan_sel = SEL_BRIGHT;
    end
  endfunction
  // semi-transparent only for the one colour 1,0,1
  wire semi_hit = semi_transparent_enable_bit & ov1_sync_reg[1] &
                  ~ov2_sync_reg[1] & ov3_sync_reg[1];
  // amplitude clipped: codes above the ceiling would overrun 5.5 v
  wire [7:0] amp_code = (overlay_amp_reg > `OVERLAY_MAX_CODE) ?
                        `OVERLAY_MAX_CODE : overlay_amp_reg;
  wire [15:0] amp_10mv = amp_code * `OVERLAY_STEP_10MV;
  // =====================================================
  // registered outputs
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      sda_oe_n_out <= 1'b1;
      clamp_gate_pulse_out <= 1'b0;
      picture_mute_out <= 1'b0;
      infra_black_out <= 1'b0;
      channel_sel_first_out <= SEL_VIDEO;
      channel_sel_second_out <= SEL_VIDEO;
      channel_sel_third_out <= SEL_VIDEO;
      contrast_gain_out <= `RST_CONTRAST;
      brightness_offset_out <= `RST_BRIGHTNESS;
      drive_first_out <= `RST_DRIVE;
      drive_second_out <= `RST_DRIVE;
      drive_third_out <= `RST_DRIVE;
      overlay_amp_10mv_out <= 16'h0000;
    end else begin
      sda_oe_n_out <= bus_oe_n;
      clamp_gate_pulse_out <= gate;
      // inputs to clamp reference while fast blank high, except in the semi-transparent colour
      picture_mute_out <= fast_blank & ~semi_hit;
      // infra-black during blanking, no brightness
      infra_black_out <= blank_act;
      brightness_offset_out <= blank_act ? 8'h00 : brightness_reg;
      channel_sel_first_out <= chan_sel(fast_blank, ov1_sync_reg[1], semi_hit);
      channel_sel_second_out <= chan_sel(fast_blank, ov2_sync_reg[1], semi_hit);
      channel_sel_third_out <= chan_sel(fast_blank, ov3_sync_reg[1], semi_hit);
      // half contrast in semi-transparent colour
      contrast_gain_out <= (fast_blank & semi_hit) ? {1'b0, contrast_reg[7:1]} : contrast_reg;
      drive_first_out <= drive_first_reg;
      drive_second_out <= drive_second_reg;
      drive_third_out <= drive_third_reg;
      overlay_amp_10mv_out <= (amp_10mv > `OVERLAY_MAX_10MV) ? `OVERLAY_MAX_10MV : amp_10mv;
    end
  end
endmodule
`default_nettype wire

// ==== overlay_clamp_checker.sv ====
// port assertions for the rgb overlay clamp control block
`timescale 1ns/100ps
`default_nettype none
module overlay_clamp_checker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_oe_n_out,
  input wire logic fast_blank_input_in,
  input wire logic overlay_in_first_in,
  input wire logic overlay_in_second_in,
  input wire logic overlay_in_third_in,
  input wire logic clamp_gate_pulse_out,
  input wire logic picture_mute_out,
  input wire logic infra_black_out,
  input wire logic [1:0] channel_sel_first_out,
  input wire logic [1:0] channel_sel_second_out,
  input wire logic [1:0] channel_sel_third_out,
  input wire logic [7:0] contrast_gain_out,
  input wire logic [7:0] brightness_offset_out,
  input wire logic [7:0] drive_first_out,
  input wire logic [15:0] overlay_amp_10mv_out
);
  logic [15:0] hi_cnt_reg;
  logic [5:0] sels;
  logic [2:0] ov;
  assign sels = {channel_sel_first_out, channel_sel_second_out, channel_sel_third_out};
  assign ov = {overlay_in_first_in, overlay_in_second_in, overlay_in_third_in};
  // ==========================================
  // gate high time, cleared while low
  always @(posedge clk_in) begin
    if (!rst_n_in || !clamp_gate_pulse_out) begin
      hi_cnt_reg <= 16'h0000;
    end else begin
      hi_cnt_reg <= hi_cnt_reg + 16'h0001;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================
  // assertions, four samples cover the 3 clk video path
  property p_video;
    !fast_blank_input_in [*4] |-> sels == 6'h00 && !picture_mute_out;
  endproperty
  a_video: assert property (p_video) else $error("video not passed");
  property p_level;
    (fast_blank_input_in && !ov[2]) [*4] |-> channel_sel_first_out == 2'h1 && picture_mute_out;
  endproperty
  a_level: assert property (p_level) else $error("no brightness level");
  property p_overlay;
    (fast_blank_input_in && ov[1]) [*4] |-> channel_sel_second_out == 2'h2 && picture_mute_out;
  endproperty
  a_overlay: assert property (p_overlay) else $error("no overlay level");
  property p_semi;
    (fast_blank_input_in && ov == 3'h5) [*4] |->
      (sels == 6'h26 && picture_mute_out) || (sels == 6'h3f && !picture_mute_out);
  endproperty
  a_semi: assert property (p_semi) else $error("bad colour 101 steering");
  property p_infra;
    infra_black_out |-> brightness_offset_out == 8'h00;
  endproperty
  a_infra: assert property (p_infra) else $error("offset during blanking");
  property p_amp;
    overlay_amp_10mv_out % 16'h0024 == 16'h0000 && overlay_amp_10mv_out <= 16'h0226;
  endproperty
  a_amp: assert property (p_amp) else $error("overlay amplitude off step");
  property p_width;
    $fell(clamp_gate_pulse_out) |-> hi_cnt_reg == 16'h0042 || hi_cnt_reg == 16'h0084 ||
      hi_cnt_reg == 16'h00c8 || hi_cnt_reg == 16'h010a;
  endproperty
  a_width: assert property (p_width) else $error("gate width not a width code");
  property p_ack_low;
    $fell(sda_oe_n_out) |-> !scl_in;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack driven with clock high");
  property p_ack_len;
    $fell(sda_oe_n_out) |-> !sda_oe_n_out [*8] ##[1:24] sda_oe_n_out;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack length wrong");
  property p_por;
    $rose(rst_n_in) |-> contrast_gain_out == 8'hb3 && drive_first_out == 8'hb3 && sels == 6'h00;
  endproperty
  a_por: assert property (p_por) else $error("reset values wrong");
endmodule
`default_nettype wire

// ==== host_serial_model.sv ====
// host model writing the preamp registers over the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module host_serial_model (
  output logic scl_out,
  output logic sda_out,
  input wire logic sda_in
);
  // ==========================================
  // idle: both lines released, clock stands high between frames
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_out = b[i];
      #20 scl_out = 1'b1;
      #40 scl_out = 1'b0;
      #20;
    end
    sda_out = 1'b1;
    #20 scl_out = 1'b1;
    ack = sda_in;
    #40 scl_out = 1'b0;
    #20;
  endtask
  // start, address, index, data, stop
  task automatic write_regs(input logic [7:0] adr, input logic [7:0] idx,
                            input logic [7:0] dat, output logic [2:0] acks);
    sda_out = 1'b0;
    #20 scl_out = 1'b0;
    #20;
    put_byte(adr, acks[2]);
    put_byte(idx, acks[1]);
    put_byte(dat, acks[0]);
    sda_out = 1'b0;
    #20 scl_out = 1'b1;
    #20 sda_out = 1'b1;
    #40;
  endtask
endmodule
`default_nettype wire

// ==== rgb_overlay_clamp_control_tb.sv ====
// self-checking bench of the rgb overlay clamp control block
`timescale 1ns/100ps
`default_nettype none
`include "preamp_consts.vh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module rgb_overlay_clamp_control_tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic fb = 1'b0;
  logic blanking_input = 1'b0;
  logic hs = 1'b1;
  logic look = 1'b0;
  logic [2:0] ov = 3'h0;
  logic [2:0] acks;
  logic [7:0] regs [6];
  logic [15:0] meas;
  logic [15:0] e;
  logic [15:0] cur_exp;
  logic dly_ok;
  logic [15:0] widths [4] = '{16'(`GATE_W0_CYC), 16'(`GATE_W1_CYC), 16'(`GATE_W2_CYC),
                              16'(`GATE_W3_CYC)};
  int cur_sel;
  int seed;
  int errors = 0;
  int total_checks = 0;
  int sel_q[$];
  logic [15:0] exp_q[$];
  string nm [12] = '{"contrast", "bright", "drive1", "drive2", "drive3", "amp", "sels",
                     "mute", "infra", "width", "acks", "delay"};
  wire scl, sda_host, sda_oe_n, sda, gate, mute, infra;
  wire [1:0] s1, s2, s3;
  wire [7:0] con, bri, d1, d2, d3;
  wire [15:0] amp;
  // pull-up: low when either party pulls
  assign sda = sda_host & sda_oe_n;
  always #2.5 clk_in = ~clk_in;
  rgb_overlay_clamp_control rgb_overlay_clamp_control_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
    .sda_oe_n_out(sda_oe_n), .fast_blank_input_in(fb), .blanking_input_in(blanking_input),
    .hsync_in(hs), .overlay_in_first_in(ov[2]), .overlay_in_second_in(ov[1]),
    .overlay_in_third_in(ov[0]), .clamp_gate_pulse_out(gate), .picture_mute_out(mute),
    .infra_black_out(infra), .channel_sel_first_out(s1), .channel_sel_second_out(s2),
    .channel_sel_third_out(s3), .contrast_gain_out(con), .brightness_offset_out(bri),
    .drive_first_out(d1), .drive_second_out(d2), .drive_third_out(d3),
    .overlay_amp_10mv_out(amp)
  );
  host_serial_model host_serial_model_i (.scl_out(scl), .sda_out(sda_host), .sda_in(sda));
  // ==========================================
  // helpers
  function automatic logic [15:0] observe(input int s);
    case (s)
      0: return {8'h00, con};
      1: return {8'h00, bri};
      2: return {8'h00, d1};
      3: return {8'h00, d2};
      4: return {8'h00, d3};
      5: return amp;
      6: return {10'h000, s1, s2, s3};
      7: return {15'h0000, mute};
      8: return {15'h0000, infra};
      9: return meas;
      10: return {13'h0000, acks};
      default: return {15'h0000, dly_ok};
    endcase
  endfunction
  task automatic expect_val(input int s, input logic [15:0] x);
    sel_q.push_back(s);
    exp_q.push_back(x);
  endtask
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic settle();
    repeat (8) @(posedge clk_in);
    #1 look = 1'b1;
    tick();
    look = 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    host_serial_model_i.write_regs(`SLAVE_ADDR_WR, idx, dat, acks);
  endtask
  task automatic measure();
    int n;
    n = 0;
    meas = 16'h0000;
    while (gate !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    dly_ok = n >= 2 && n <= 8;
    while (gate === 1'b1 && meas < 16'h0190) begin
      tick();
      meas++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // watcher: every queued note, oldest first, against the outputs
  always @(negedge clk_in) begin
    if (look) begin
      while (sel_q.size() > 0) begin
        cur_sel = sel_q.pop_front();
        cur_exp = exp_q.pop_front();
        `CHK(nm[cur_sel], cur_exp, observe(cur_sel))
      end
    end
  end
  // watchdog, run needs well under 100 us
  initial begin
    #300000;
    errors++;
    report_and_stop();
  end
  initial begin
    seed = 4;
    repeat (2) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    for (int i = 0; i < 5; i++) expect_val(i, i == 1 ? 16'h0000 : 16'h00b3);
    expect_val(5, 16'h0000);
    settle();
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      regs[i] = 8'($random(seed));
      wr(i[7:0], regs[i]);
      expect_val(10, 16'h0000);
      settle();
    end
    for (int i = 0; i < 5; i++) expect_val(i, {8'h00, regs[i]});
    e = regs[5] > 8'h0f ? 16'h000f : {8'h00, regs[5]};
    expect_val(5, e * 16'h0024);
    host_serial_model_i.write_regs(8'hdd, `REG_CONTRAST, ~regs[0], acks);
    expect_val(10, 16'h0007);
    expect_val(0, {8'h00, regs[0]});
    settle();
    $display("test register writes done");
    for (int k = 0; k < 16; k++) begin
      if (k == 8) wr(`REG_CLAMP_CONFIG, 8'h40);
      tick();
      fb = 1'b1;
      ov = k[2:0];
      e = 16'h0000;
      for (int c = 2; c >= 0; c--) e = {e[13:0], ov[c] ? 2'h2 : 2'h1};
      if (k >= 8 && ov == 3'h5) e = 16'h003f;
      expect_val(6, e);
      expect_val(7, {15'h0000, e != 16'h003f});
      expect_val(0, e == 16'h003f ? {9'h000, regs[0][7:1]} : {8'h00, regs[0]});
      settle();
    end
    tick();
    fb = 1'b0;
    expect_val(6, 16'h0000);
    expect_val(7, 16'h0000);
    settle();
    $display("test overlay steering done");
    for (int p = 0; p < 2; p++) begin
      wr(`REG_CLAMP_CONFIG, {p[0], 7'h40});
      for (int b = 0; b < 2; b++) begin
        tick();
        blanking_input = b[0];
        expect_val(8, {15'h0000, b[0] ^ p[0]});
        expect_val(1, (b[0] ^ p[0]) ? 16'h0000 : {8'h00, regs[1]});
        settle();
      end
    end
    $display("test blanking done");
    tick();
    blanking_input = 1'b0;
    for (int w = 0; w < 4; w++) begin
      wr(`REG_CLAMP_CONFIG, {5'h00, w[1:0], 1'b1});
      tick();
      blanking_input = 1'b1;
      measure();
      expect_val(9, widths[w]);
      settle();
      blanking_input = 1'b0;
    end
    $display("test blanking gate done");
    wr(`REG_CLAMP_CONFIG, 8'h02);
    // negative line pulses, matching the low-active polarity the vote holds from reset
    for (int l = 0; l < 8; l++) begin
      tick();
      hs = 1'b0;
      repeat (20) tick();
      hs = 1'b1;
      measure();
      repeat (100) @(posedge clk_in);
    end
    expect_val(9, widths[1]);
    expect_val(11, 16'h0001);
    settle();
    $display("test line sync gate done");
    // long low idle so the vote swings over to positive pulses
    tick();
    hs = 1'b0;
    repeat (700) tick();
    hs = 1'b1;
    repeat (20) tick();
    hs = 1'b0;
    measure();
    expect_val(9, widths[1]);
    expect_val(11, 16'h0001);
    settle();
    $display("test positive sync gate done");
    // mid-run reset drops every written code
    tick();
    rst_n_in = 1'b0;
    repeat (2) tick();
    rst_n_in = 1'b1;
    for (int i = 0; i < 5; i++) expect_val(i, i == 1 ? 16'h0000 : 16'h00b3);
    expect_val(5, 16'h0000);
    settle();
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule
bind rgb_overlay_clamp_control overlay_clamp_checker overlay_clamp_checker_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_oe_n_out(sda_oe_n_out),
  .fast_blank_input_in(fast_blank_input_in), .overlay_in_first_in(overlay_in_first_in),
  .overlay_in_second_in(overlay_in_second_in), .overlay_in_third_in(overlay_in_third_in),
  .clamp_gate_pulse_out(clamp_gate_pulse_out), .picture_mute_out(picture_mute_out),
  .infra_black_out(infra_black_out), .channel_sel_first_out(channel_sel_first_out),
  .channel_sel_second_out(channel_sel_second_out),
  .channel_sel_third_out(channel_sel_third_out), .contrast_gain_out(contrast_gain_out),
  .brightness_offset_out(brightness_offset_out), .drive_first_out(drive_first_out),
  .overlay_amp_10mv_out(overlay_amp_10mv_out)
);
`default_nettype wire
